// ---- mief_unit.sv ----
// Interrupt enable and flag unit: event capture, masking, edge detection and register port
// Notes on behaviour
// R1 - The main enable register at 0xE holds enables in bits 0,1,2,3,4,6, all reset to zero.
// R2 - The main flag register at 0xF holds one flag per source in the same bits, set by events, reset to zero.
// R3 - Flags are never cleared by hardware; software clears them by writing, otherwise they stay set.
// R4 - A flag whose enable is clear reads back as zero.
// R5 - A port B input change sets the port change flag.
// R6 - Timer1 underflow sets bit 3, watchdog timeout bit 6, low-voltage detection bit 4.
// R7 - The secondary enable register at 0x17 holds the write-done enable in bit 4, reset zero.
// R8 - The secondary flag register at 0x1F holds the write-done flag in bit 4, set by hardware, cleared by software.
// R9 - Bit 4 of the edge register at 0x18 makes port B bit 0 the external interrupt input.
// R10 - Edge field bits 1:0: 01 rising, 10 falling, 11 both, 00 reserved; reset is rising.
// R11 - The selected edge on the external input sets the external pin flag.
// R12 - A global gate bit blocks every interrupt when clear.
// R13 - The request is high in the cycle after the gate is set and some flag is set with its enable.
// R14 - With edge code 00 no external edge is detected.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module mief_unit #(
    parameter int PORT_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [mief_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Event sources, one-cycle pulses
    input wire mief_pkg::mief_events_t events,
    // Port B pin levels, bit 0 is the external interrupt pin
    input wire logic [PORT_W-1:0] port_b_pins,
    // Request to the core and pin function
    output logic irq_request,
    output logic ext_pin_function_sel
);
    // The pin history and change logic serve one port of at most eight pins
    if (PORT_W < 1 || PORT_W > 8) begin : g_bad_port_w
        $error("PORT_W must be 1 to 8");
    end

    logic [7:0] irq_enable_main;
    logic [7:0] irq_flag_main;
    logic [7:0] irq_enable_secondary;
    logic [7:0] irq_flag_secondary;
    logic [7:0] ext_pin_edge_config;
    logic global_irq_gate;
    logic [PORT_W-1:0] port_prev;
    logic port_b_bit_zero_prev;

    // Address decode
    wire wr_en_main = reg_write && reg_addr == mief_pkg::OFS_ENABLE_MAIN;
    wire wr_flag_main = reg_write && reg_addr == mief_pkg::OFS_FLAG_MAIN;
    wire wr_en_sec = reg_write && reg_addr == mief_pkg::OFS_ENABLE_SECONDARY;
    wire wr_edge = reg_write && reg_addr == mief_pkg::OFS_EDGE_CONFIG;
    wire wr_flag_sec = reg_write && reg_addr == mief_pkg::OFS_FLAG_SECONDARY;
    wire wr_gate = reg_write && reg_addr == mief_pkg::OFS_GLOBAL_GATE;

    // Edge detection on port B bit 0
    wire port_b_bit_zero = port_b_pins[0];
    wire [1:0] edge_trigger_sel = ext_pin_edge_config[1:0];
    wire rise = port_b_bit_zero && !port_b_bit_zero_prev;
    wire fall = !port_b_bit_zero && port_b_bit_zero_prev;
    wire ext_edge = ext_pin_function_sel && ( // R9
        (edge_trigger_sel == mief_pkg::EDGE_RISING && rise) || // R10
        (edge_trigger_sel == mief_pkg::EDGE_FALLING && fall) ||
        (edge_trigger_sel == mief_pkg::EDGE_BOTH && (rise || fall))); // R14
    wire port_change = |(port_b_pins ^ port_prev); // R5

    // Set vector for the main flag register
    logic [7:0] set_main;
    always_comb begin
        set_main = 8'h00;
        set_main[mief_pkg::BIT_TIMER_ZERO] = events.timer_zero_overflow;
        set_main[mief_pkg::BIT_PORT_CHANGE] = port_change; // R5
        set_main[mief_pkg::BIT_EXT_PIN] = ext_edge; // R11
        set_main[mief_pkg::BIT_TIMER_ONE] = events.timer_one_underflow; // R6
        set_main[mief_pkg::BIT_LOW_VOLTAGE] = events.low_voltage; // R6
        set_main[mief_pkg::BIT_WATCHDOG] = events.watchdog_timeout; // R6
    end
    wire [7:0] set_sec = {3'h0, events.nvm_write_done, 4'h0};

    // Writing a flag register stores the written value; a zero clears, and a set wins
    wire [7:0] keep_main = wr_flag_main ? reg_wdata : irq_flag_main;
    wire [7:0] keep_sec = wr_flag_sec ? reg_wdata : irq_flag_secondary;
    wire [7:0] next_flag_main = (keep_main | set_main) & mief_pkg::MAIN_MASK; // R2 R3
    wire [7:0] next_flag_sec = (keep_sec | set_sec) & mief_pkg::SECONDARY_MASK; // R8 R3

    // Masked flag views for read-back and request
    wire [7:0] seen_main = irq_flag_main & irq_enable_main; // R4
    wire [7:0] seen_sec = irq_flag_secondary & irq_enable_secondary; // R4
    wire next_irq = global_irq_gate && (|seen_main || |seen_sec); // R12 R13

    logic [7:0] next_rdata;
    always_comb begin
        case (reg_addr)
            mief_pkg::OFS_ENABLE_MAIN: next_rdata = irq_enable_main;
            mief_pkg::OFS_FLAG_MAIN: next_rdata = seen_main; // R4
            mief_pkg::OFS_ENABLE_SECONDARY: next_rdata = irq_enable_secondary;
            mief_pkg::OFS_EDGE_CONFIG: next_rdata = ext_pin_edge_config;
            mief_pkg::OFS_FLAG_SECONDARY: next_rdata = seen_sec;
            mief_pkg::OFS_GLOBAL_GATE: next_rdata = {7'h00, global_irq_gate};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_enable_main <= mief_pkg::ENABLE_RESET; // R1
            irq_enable_secondary <= mief_pkg::ENABLE_RESET; // R7
            ext_pin_edge_config <= mief_pkg::EDGE_CFG_RESET; // R10
            global_irq_gate <= 1'b0;
        end else begin
            if (wr_en_main) begin
                irq_enable_main <= reg_wdata & mief_pkg::MAIN_MASK; // R1
            end
            if (wr_en_sec) begin
                irq_enable_secondary <= reg_wdata & mief_pkg::SECONDARY_MASK; // R7
            end
            if (wr_edge) begin
                ext_pin_edge_config <= reg_wdata & mief_pkg::EDGE_CFG_MASK; // R9
            end
            if (wr_gate) begin
                global_irq_gate <= reg_wdata[mief_pkg::BIT_GLOBAL_GATE]; // R12
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_flag_main <= mief_pkg::FLAG_RESET;
            irq_flag_secondary <= mief_pkg::FLAG_RESET;
            irq_request <= 1'b0;
            reg_rdata <= 8'h00;
            ext_pin_function_sel <= 1'b0;
        end else begin
            irq_flag_main <= next_flag_main;
            irq_flag_secondary <= next_flag_sec;
            irq_request <= next_irq; // R13
            reg_rdata <= reg_read ? next_rdata : 8'h00;
            ext_pin_function_sel <= wr_edge ? reg_wdata[mief_pkg::BIT_FUNC_SEL]
                                            : ext_pin_function_sel; // R9
        end
    end

    // Pin history is cleared to zero and then follows the pins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port_prev <= '0;
            port_b_bit_zero_prev <= 1'b0;
        end else begin
            port_prev <= port_b_pins;
            port_b_bit_zero_prev <= port_b_pins[0];
        end
    end

    // Assertions
    property p_enable_reset;
        @(posedge clock) $fell(sys_rst) |-> irq_enable_main == 8'h00 && irq_enable_secondary == 8'h00;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("enables not zero after reset"); // R1

    property p_flag_set;
        @(posedge clock) disable iff (sys_rst)
            events.timer_one_underflow |=> irq_flag_main[3];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("timer1 flag not set"); // R6

    property p_flag_sticky;
        @(posedge clock) disable iff (sys_rst)
            irq_flag_main[6] && !wr_flag_main |=> irq_flag_main[6];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without write"); // R3

    property p_masked_read;
        @(posedge clock) disable iff (sys_rst)
            reg_read && reg_addr == 5'h0F && !irq_enable_main[0] |=> !reg_rdata[0];
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("disabled flag read as one"); // R4

    property p_nvm_flag;
        @(posedge clock) disable iff (sys_rst)
            events.nvm_write_done |=> irq_flag_secondary[4];
    endproperty
    a_nvm_flag: assert property (p_nvm_flag) else $error("write-done flag not set"); // R8

    property p_rise;
        @(posedge clock) disable iff (sys_rst)
            ext_pin_function_sel && ext_pin_edge_config[1:0] == 2'h1 && rise
            |=> irq_flag_main[2];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed"); // R11

    property p_reserved;
        @(posedge clock) disable iff (sys_rst)
            ext_pin_edge_config[1:0] == 2'h0 && !irq_flag_main[2] && !wr_flag_main
            |=> !irq_flag_main[2];
    endproperty
    a_reserved: assert property (p_reserved) else $error("edge seen with reserved code"); // R14

    property p_gate;
        @(posedge clock) disable iff (sys_rst)
            !global_irq_gate |=> !irq_request;
    endproperty
    a_gate: assert property (p_gate) else $error("request with gate clear"); // R12

    property p_request;
        @(posedge clock) disable iff (sys_rst)
            global_irq_gate && (irq_flag_main[1] && irq_enable_main[1]) |=> irq_request;
    endproperty
    a_request: assert property (p_request) else $error("request missing"); // R13

    property p_port_change;
        @(posedge clock) disable iff (sys_rst)
            port_b_pins != port_prev |=> irq_flag_main[1];
    endproperty
    a_port_change: assert property (p_port_change) else $error("port change missed"); // R5

    property p_cfg_reset;
        @(posedge clock)
            $fell(sys_rst) |-> ext_pin_edge_config == 8'h01 && !ext_pin_function_sel;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("edge config reset"); // R10

    property p_flag_reset;
        @(posedge clock)
            $fell(sys_rst) |-> irq_flag_main == 8'h00 && irq_flag_secondary == 8'h00;
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("flags not zero after reset"); // R2

    property p_gate_reset;
        @(posedge clock)
            $fell(sys_rst) |-> !global_irq_gate && !irq_request;
    endproperty
    a_gate_reset: assert property (p_gate_reset) else $error("gate set after reset"); // R12

    property p_t0_flag;
        @(posedge clock) disable iff (sys_rst)
            events.timer_zero_overflow |=> irq_flag_main[0];
    endproperty
    a_t0_flag: assert property (p_t0_flag) else $error("timer0 flag not set"); // R2

    property p_lv_flag;
        @(posedge clock) disable iff (sys_rst)
            events.low_voltage |=> irq_flag_main[4];
    endproperty
    a_lv_flag: assert property (p_lv_flag) else $error("low-voltage flag not set"); // R6

    property p_wd_flag;
        @(posedge clock) disable iff (sys_rst)
            events.watchdog_timeout |=> irq_flag_main[6];
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag not set"); // R6

    property p_fall;
        @(posedge clock) disable iff (sys_rst)
            ext_pin_function_sel && ext_pin_edge_config[1:0] == 2'h2 && fall
            |=> irq_flag_main[2];
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge missed"); // R11

    property p_both;
        @(posedge clock) disable iff (sys_rst)
            ext_pin_function_sel && ext_pin_edge_config[1:0] == 2'h3 && (rise || fall)
            |=> irq_flag_main[2];
    endproperty
    a_both: assert property (p_both) else $error("edge missed in both-edge mode"); // R11

    property p_gpio;
        @(posedge clock) disable iff (sys_rst)
            !ext_pin_function_sel && !irq_flag_main[2] && !wr_flag_main |=> !irq_flag_main[2];
    endproperty
    a_gpio: assert property (p_gpio) else $error("external flag set in pin mode"); // R9

    property p_sticky_all;
        @(posedge clock) disable iff (sys_rst)
            !wr_flag_main |=> (irq_flag_main & $past(irq_flag_main)) == $past(irq_flag_main);
    endproperty
    a_sticky_all: assert property (p_sticky_all) else $error("main flag lost"); // R3

    property p_sec_sticky;
        @(posedge clock) disable iff (sys_rst)
            irq_flag_secondary[4] && !wr_flag_sec |=> irq_flag_secondary[4];
    endproperty
    a_sec_sticky: assert property (p_sec_sticky) else $error("write-done flag lost"); // R8

    property p_clear;
        @(posedge clock) disable iff (sys_rst)
            wr_flag_main && reg_wdata == 8'h00 && !events.timer_zero_overflow
            |=> !irq_flag_main[0];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared by write"); // R3

    property p_sec_clear;
        @(posedge clock) disable iff (sys_rst)
            wr_flag_sec && !reg_wdata[4] && !events.nvm_write_done
            |=> !irq_flag_secondary[4];
    endproperty
    a_sec_clear: assert property (p_sec_clear) else $error("write-done flag not cleared"); // R8

    property p_unused_main;
        @(posedge clock) disable iff (sys_rst)
            ((irq_enable_main | irq_flag_main) & 8'hA0) == 8'h00;
    endproperty
    a_unused_main: assert property (p_unused_main) else $error("unused main bit set"); // R1

    property p_unused_sec;
        @(posedge clock) disable iff (sys_rst)
            ((irq_enable_secondary | irq_flag_secondary) & 8'hEF) == 8'h00;
    endproperty
    a_unused_sec: assert property (p_unused_sec) else $error("unused secondary bit set"); // R7

    property p_en_write;
        @(posedge clock) disable iff (sys_rst)
            wr_en_main |=> irq_enable_main == ($past(reg_wdata) & 8'h5F);
    endproperty
    a_en_write: assert property (p_en_write) else $error("main enable write lost"); // R1

    property p_en2_write;
        @(posedge clock) disable iff (sys_rst)
            wr_en_sec |=> irq_enable_secondary == ($past(reg_wdata) & 8'h10);
    endproperty
    a_en2_write: assert property (p_en2_write) else $error("secondary enable write lost"); // R7

    property p_cfg_write;
        @(posedge clock) disable iff (sys_rst)
            wr_edge |=> ext_pin_edge_config == ($past(reg_wdata) & 8'h13);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("edge config write lost"); // R10

    property p_func_copy;
        @(posedge clock) disable iff (sys_rst)
            ext_pin_function_sel == ext_pin_edge_config[4];
    endproperty
    a_func_copy: assert property (p_func_copy) else $error("pin function differs"); // R9

    property p_masked_sec;
        @(posedge clock) disable iff (sys_rst)
            reg_read && reg_addr == 5'h1F && !irq_enable_secondary[4] |=> !reg_rdata[4];
    endproperty
    a_masked_sec: assert property (p_masked_sec) else $error("disabled write-done read"); // R4

    property p_read_flags;
        @(posedge clock) disable iff (sys_rst)
            reg_read && reg_addr == 5'h0F
            |=> reg_rdata == ($past(irq_flag_main) & $past(irq_enable_main));
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("flag read not masked"); // R4

    property p_request_sec;
        @(posedge clock) disable iff (sys_rst)
            global_irq_gate && irq_flag_secondary[4] && irq_enable_secondary[4]
            |=> irq_request;
    endproperty
    a_request_sec: assert property (p_request_sec) else $error("write-done request missing"); // R13

    property p_no_request;
        @(posedge clock) disable iff (sys_rst)
            ~|(irq_flag_main & irq_enable_main) && ~|(irq_flag_secondary & irq_enable_secondary)
            |=> !irq_request;
    endproperty
    a_no_request: assert property (p_no_request) else $error("request without flag"); // R13
endmodule

// ---- mief_pkg.sv ----
// Package: register map, field layout and reset values of the interrupt enable and flag unit
package mief_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_ENABLE_MAIN = 5'h0E;
    localparam logic [4:0] OFS_FLAG_MAIN = 5'h0F;
    localparam logic [4:0] OFS_ENABLE_SECONDARY = 5'h17;
    localparam logic [4:0] OFS_EDGE_CONFIG = 5'h18;
    localparam logic [4:0] OFS_FLAG_SECONDARY = 5'h1F;
    localparam logic [4:0] OFS_GLOBAL_GATE = 5'h1A;
    localparam int BIT_TIMER_ZERO = 0;
    localparam int BIT_PORT_CHANGE = 1;
    localparam int BIT_EXT_PIN = 2;
    localparam int BIT_TIMER_ONE = 3;
    localparam int BIT_LOW_VOLTAGE = 4;
    localparam int BIT_WATCHDOG = 6;
    localparam int BIT_NVM_DONE = 4;
    localparam int BIT_FUNC_SEL = 4;
    localparam int BIT_GLOBAL_GATE = 0;
    localparam logic [7:0] MAIN_MASK = 8'h5F;
    localparam logic [7:0] SECONDARY_MASK = 8'h10;
    localparam logic [7:0] EDGE_CFG_MASK = 8'h13;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] EDGE_CFG_RESET = 8'h01;
    localparam logic [1:0] EDGE_RESERVED = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic timer_zero_overflow;
        logic port_change;
        logic timer_one_underflow;
        logic low_voltage;
        logic watchdog_timeout;
        logic nvm_write_done;
    } mief_events_t;
endpackage

// ---- mief_src.sv ----
// Partner model: peripheral event sources and port B pin drivers
`timescale 1ns/1ps
module mief_src (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Requests from the bench
    input wire mief_pkg::mief_events_t fire_req,
    input wire logic [5:0] pin_req,
    // Towards the unit
    output mief_pkg::mief_events_t events,
    output logic [5:0] pins
);
    // A one-cycle request gives a one-cycle event pulse
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            events <= '0;
            pins <= 6'h00;
        end else begin
            events <= fire_req;
            pins <= pin_req;
        end
    end
endmodule

// ---- mief_unit_tb.sv ----
// Self-checking testbench of the interrupt enable and flag unit
`timescale 1ns/1ps
module mief_unit_tb;
    localparam logic [4:0] FLAG2 = 5'h1F;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic irq_request;
    logic ext_pin_function_sel;
    mief_pkg::mief_events_t fire_req = '0;
    mief_pkg::mief_events_t events;
    logic [5:0] pin_req = 6'h00;
    logic [5:0] port_b_pins;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    always #4 clock = ~clock;

    mief_unit #(.PORT_W(6)) mief_unit_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .events(events), .port_b_pins(port_b_pins),
        .irq_request(irq_request), .ext_pin_function_sel(ext_pin_function_sel));
    mief_src mief_src_i (.clock(clock), .sys_rst(sys_rst), .fire_req(fire_req),
        .pin_req(pin_req), .events(events), .pins(port_b_pins));

    task automatic give_verdict;
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Event pulse or pin change, then wait until it has reached the flags
    task automatic stim(input logic [5:0] ev, input logic [5:0] p);
        @(posedge clock);
        fire_req <= ev;
        pin_req <= p;
        @(posedge clock);
        fire_req <= '0;
        repeat (2) @(posedge clock);
    endtask

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clock);
        #1;
        chk({7'h00, irq_request}, {7'h00, exp});
    endtask

    task automatic t_reset_values;
        rd(mief_pkg::OFS_ENABLE_MAIN, 8'h00);
        rd(mief_pkg::OFS_FLAG_MAIN, 8'h00);
        rd(mief_pkg::OFS_ENABLE_SECONDARY, 8'h00);
        rd(mief_pkg::OFS_EDGE_CONFIG, 8'h01);
        rd(FLAG2, 8'h00);
        rd(mief_pkg::OFS_GLOBAL_GATE, 8'h00);
        rd(5'h00, 8'h00);
    endtask

    task automatic t_main_flags;
        stim(6'h2E, 6'h00);
        rd(mief_pkg::OFS_FLAG_MAIN, 8'h00);
        wr(mief_pkg::OFS_ENABLE_MAIN, 8'hFF);
        rd(mief_pkg::OFS_ENABLE_MAIN, 8'h5F);
        rd(mief_pkg::OFS_FLAG_MAIN, 8'h59);
        irq_is(1'b0);
        wr(mief_pkg::OFS_GLOBAL_GATE, 8'h01);
        rd(mief_pkg::OFS_GLOBAL_GATE, 8'h01);
        irq_is(1'b1);
        wr(mief_pkg::OFS_ENABLE_MAIN, 8'h00);
        irq_is(1'b0);
        wr(mief_pkg::OFS_ENABLE_MAIN, 8'hFF);
        wr(mief_pkg::OFS_FLAG_MAIN, 8'h00);
        rd(mief_pkg::OFS_FLAG_MAIN, 8'h00);
        irq_is(1'b0);
    endtask

    task automatic t_nvm_done;
        wr(mief_pkg::OFS_ENABLE_SECONDARY, 8'hFF);
        rd(mief_pkg::OFS_ENABLE_SECONDARY, 8'h10);
        stim(6'h01, 6'h00);
        rd(FLAG2, 8'h10);
        irq_is(1'b1);
        wr(FLAG2, 8'h00);
        rd(FLAG2, 8'h00);
    endtask

    task automatic t_pins;
        logic [1:0] code;
        stim(6'h00, 6'h08);
        rd(mief_pkg::OFS_FLAG_MAIN, 8'h02);
        stim(6'h00, 6'h00);
        for (int i = 0; i < 4; i++) begin
            code = i[1:0];
            wr(mief_pkg::OFS_EDGE_CONFIG, {6'h04, code});
            rd(mief_pkg::OFS_EDGE_CONFIG, {6'h04, code});
            chk({7'h00, ext_pin_function_sel}, 8'h01);
            wr(mief_pkg::OFS_FLAG_MAIN, 8'h00);
            stim(6'h00, 6'h01);
            rd(mief_pkg::OFS_FLAG_MAIN, {5'h00, code[0], 2'h2});
            wr(mief_pkg::OFS_FLAG_MAIN, 8'h00);
            stim(6'h00, 6'h00);
            rd(mief_pkg::OFS_FLAG_MAIN, {5'h00, code[1], 2'h2});
        end
        wr(mief_pkg::OFS_EDGE_CONFIG, 8'h03);
        wr(mief_pkg::OFS_FLAG_MAIN, 8'h00);
        stim(6'h00, 6'h01);
        rd(mief_pkg::OFS_FLAG_MAIN, 8'h02);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset_values();
        t_main_flags();
        t_nvm_done();
        t_pins();
        give_verdict();
    end
endmodule
